// ---- logic/tllc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module tllc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    // Fill side
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    // Drain side
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("tllc_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } tllc_fifo_st_t;

    tllc_fifo_st_t    st;
    tllc_fifo_st_t    next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full  = (st.wptr[AW] != st.rptr[AW]) && (st.wptr[AW-1:0] == st.rptr[AW-1:0]);
    assign empty = st.wptr == st.rptr;
    assign push  = wr_valid_in && !full;
    assign pop   = rd_ready_in && !empty;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem[st.rptr[AW-1:0]];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wptr[AW-1:0]] <= wr_data_in;
        end
    end
endmodule
`default_nettype wire

// ---- logic/tllc_pkg.sv ----
package tllc_pkg;

    // Functional modes of the channel
    typedef enum logic [2:0] {
        TLLC_MODE_BASIC,
        TLLC_MODE_DETLAT,
        TLLC_MODE_SDI,
        TLLC_MODE_PIPE,
        TLLC_MODE_XAUI
    } tllc_mode_t;

    // Loopback selection, one path at most
    typedef enum logic [1:0] {
        TLLC_LB_NONE,
        TLLC_LB_REV_PAR,
        TLLC_LB_SERIAL,
        TLLC_LB_REV_SER
    } tllc_lb_t;

    localparam int TLLC_WORD_W = 10;
    localparam int TLLC_SLIP_W = 5;
    localparam logic [4:0] TLLC_SLIP_MAX = 5'h09;

    // Register byte offsets
    localparam logic [7:0] TLLC_REG_CTRL   = 8'h00;
    localparam logic [7:0] TLLC_REG_SLIP   = 8'h04;
    localparam logic [7:0] TLLC_REG_STATUS = 8'h08;
    localparam logic [7:0] TLLC_REG_RECFG  = 8'h0C;

    // Control register fields
    localparam int TLLC_CTRL_MODE_LSB = 0;
    localparam int TLLC_CTRL_BOND_BIT = 4;
    localparam int TLLC_CTRL_TXREG_BIT = 5;
    localparam int TLLC_CTRL_PFD_BIT = 6;
    localparam int TLLC_CTRL_MANUAL_BIT = 7;
    localparam int TLLC_CTRL_REFEQ_BIT = 8;

    localparam logic [31:0] TLLC_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] TLLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TLLC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [9:0] data;
        logic       valid;
    } tllc_word_t;

endpackage

// ---- logic/tllc_slip.sv ----
`timescale 1ns/1ps
`default_nettype none
module tllc_slip #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    // Word stream
    input  wire logic [WIDTH-1:0] word_in,
    input  wire logic             step_in,
    input  wire logic [4:0]       slip_in,
    output logic      [WIDTH-1:0] word_out
);
    if (WIDTH < 10 || WIDTH > 16) begin
        $error("tllc_slip: WIDTH must be 10..16");
    end

    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] out;
    } tllc_slip_st_t;

    tllc_slip_st_t        st;
    tllc_slip_st_t        next_st;
    logic [2*WIDTH-1:0]   joined;
    logic [4:0]           amt;

    // Larger slip than the word would wrap, so clamp
    assign amt = (slip_in > tllc_pkg::TLLC_SLIP_MAX) ? tllc_pkg::TLLC_SLIP_MAX : slip_in;
    assign joined = {word_in, st.prev};
    assign word_out = st.out;

    always_comb begin
        next_st = st;
        if (step_in) begin
            next_st.prev = word_in;
            // Delay serial stream by amt bits, LSB first
            next_st.out  = joined[WIDTH - 32'(amt) +: WIDTH];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ---- logic/tllc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tllc_top #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Fabric transmit stream
    input  wire logic [9:0]  tx_data_in,
    input  wire logic        tx_valid_in,
    output logic             tx_ready_out,
    // Fabric receive stream
    output logic [9:0]       rx_data_out,
    output logic             rx_valid_out,
    // PIPE loopback request and power state
    input  wire logic        tx_detect_loop_in,
    input  wire logic [1:0]  power_state_in,
    // Line side
    input  wire logic [9:0]  line_rx_word_in,
    input  wire logic        line_rx_valid_in,
    input  wire logic [4:0]  align_slip_in,
    input  wire logic        align_sync_in,
    output logic [9:0]       line_tx_word_out,
    output logic             line_tx_valid_out,
    output logic             rx_buf_en_out,
    // Status
    output logic [4:0]       rx_slip_count_out,
    output logic             pfd_feedback_out,
    output logic             bonded_out
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("tllc_top: FIFO_DEPTH too small");
        end
    end

    typedef struct packed {
        logic        aw_ok;
        logic        w_ok;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [4:0]  tx_slip;
        tllc_pkg::tllc_lb_t lb_cfg;
        tllc_pkg::tllc_lb_t lb_act;
        logic [4:0]  slip_count;
        logic        pfd;
        logic        bonded;
        logic        tx_pipe_en;
        logic        slip_valid;
        tllc_pkg::tllc_word_t tx_reg;
        tllc_pkg::tllc_word_t rx_reg;
        tllc_pkg::tllc_word_t line_tx;
        logic        rx_buf_en;
    } tllc_st_t;

    tllc_st_t              st;
    tllc_st_t              next_st;
    tllc_pkg::tllc_mode_t  mode;
    logic [9:0]            fifo_data;
    logic                  fifo_valid;
    logic                  fifo_pop;
    logic [9:0]            slip_word;
    tllc_pkg::tllc_word_t  tx_src;
    tllc_pkg::tllc_word_t  rx_src;
    logic                  wr_fire;

    assign mode = tllc_pkg::tllc_mode_t'(st.ctrl[tllc_pkg::TLLC_CTRL_MODE_LSB +: 3]);

    // Transmit side drains one word per cycle whenever the FIFO holds one; the line never holds it off
    assign fifo_pop = 1'b1;

    tllc_fifo #(
        .WIDTH (tllc_pkg::TLLC_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in  (core_clk_in),
        .resetn_in    (resetn_in),
        .wr_data_in   (tx_data_in),
        .wr_valid_in  (tx_valid_in),
        .wr_ready_out (tx_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_pop)
    );

    tllc_slip #(
        .WIDTH (tllc_pkg::TLLC_WORD_W)
    ) u_slip (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .word_in     (fifo_data),
        .step_in     (fifo_valid),
        .slip_in     (st.tx_slip),
        .word_out    (slip_word)
    );

    assign wr_fire = st.aw_ok && st.w_ok && !st.bvalid;

    always_comb begin
        next_st = st;

        // AXI4-Lite write: address and data latched independently
        if (s_axi_awvalid && !st.aw_ok) begin
            next_st.aw_ok  = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_ok) begin
            next_st.w_ok  = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = tllc_pkg::TLLC_RESP_OKAY;
            unique case (st.awaddr)
                tllc_pkg::TLLC_REG_CTRL: begin
                    if (st.wstrb[0]) begin
                        next_st.ctrl[7:0] = st.wdata[7:0];
                    end
                    if (st.wstrb[1]) begin
                        next_st.ctrl[15:8] = st.wdata[15:8];
                    end
                end
                tllc_pkg::TLLC_REG_SLIP: begin
                    if (st.wstrb[0]) begin
                        next_st.tx_slip = st.wdata[4:0];
                    end
                end
                tllc_pkg::TLLC_REG_RECFG: begin
                    // Requested loopback only changes through this reconfiguration word
                    if (st.wstrb[0]) begin
                        next_st.lb_cfg = tllc_pkg::tllc_lb_t'(st.wdata[1:0]);
                    end
                end
                default: next_st.bresp = tllc_pkg::TLLC_RESP_SLVERR;
            endcase
        end

        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // AXI4-Lite read
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = tllc_pkg::TLLC_RESP_OKAY;
            unique case (s_axi_araddr)
                tllc_pkg::TLLC_REG_CTRL:   next_st.rdata = {16'h0000, st.ctrl[15:0]};
                tllc_pkg::TLLC_REG_SLIP:   next_st.rdata = {27'h0000000, st.tx_slip};
                tllc_pkg::TLLC_REG_STATUS: next_st.rdata = {23'h000000, st.lb_act,
                                               st.bonded, st.pfd, st.slip_count};
                tllc_pkg::TLLC_REG_RECFG:  next_st.rdata = {30'h00000000, st.lb_cfg};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = tllc_pkg::TLLC_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Bonding allowed in every mode except video; video mode forced single
        next_st.bonded = st.ctrl[tllc_pkg::TLLC_CTRL_BOND_BIT] && mode != tllc_pkg::TLLC_MODE_SDI;
        // Feedback only with equal reference and low-speed clocks
        next_st.pfd = mode == tllc_pkg::TLLC_MODE_DETLAT && st.ctrl[tllc_pkg::TLLC_CTRL_PFD_BIT]
                      && st.ctrl[tllc_pkg::TLLC_CTRL_REFEQ_BIT];
        next_st.tx_pipe_en = mode == tllc_pkg::TLLC_MODE_DETLAT
                             && st.ctrl[tllc_pkg::TLLC_CTRL_TXREG_BIT];

        // Capture aligner slip on sync in manual alignment
        if (st.ctrl[tllc_pkg::TLLC_CTRL_MANUAL_BIT] && align_sync_in) begin
            next_st.slip_count = align_slip_in;
        end

        // Pick one legal loopback per mode, else normal path
        next_st.lb_act = tllc_pkg::TLLC_LB_NONE;
        unique case (st.lb_cfg)
            tllc_pkg::TLLC_LB_NONE: next_st.lb_act = tllc_pkg::TLLC_LB_NONE;
            tllc_pkg::TLLC_LB_REV_PAR: begin
                // PIPE only, fabric request in power state P0
                if (mode == tllc_pkg::TLLC_MODE_PIPE && tx_detect_loop_in
                    && power_state_in == 2'h0) begin
                    next_st.lb_act = tllc_pkg::TLLC_LB_REV_PAR;
                end
            end
            tllc_pkg::TLLC_LB_SERIAL: begin
                if (mode != tllc_pkg::TLLC_MODE_PIPE) begin
                    next_st.lb_act = tllc_pkg::TLLC_LB_SERIAL;
                end
            end
            tllc_pkg::TLLC_LB_REV_SER: begin
                if (mode != tllc_pkg::TLLC_MODE_XAUI) begin
                    next_st.lb_act = tllc_pkg::TLLC_LB_REV_SER;
                end
            end
        endcase

        // Transmit path: one register stage when registered, else direct
        // Flag rides with the slip register so word and valid stay paired
        next_st.slip_valid = fifo_valid;
        tx_src.data  = slip_word;
        tx_src.valid = st.slip_valid;
        next_st.tx_reg = tx_src;
        if (st.tx_pipe_en) begin
            tx_src = st.tx_reg;
        end

        // Receive source: line, or own transmit in serial loopback
        rx_src.data  = line_rx_word_in;
        rx_src.valid = line_rx_valid_in;
        if (st.lb_act == tllc_pkg::TLLC_LB_SERIAL) begin
            rx_src = tx_src;
        end
        next_st.rx_buf_en = st.lb_act != tllc_pkg::TLLC_LB_SERIAL;
        // Receive FIFO always one register stage
        next_st.rx_reg = rx_src;

        // Line output; serial loopback keeps driving the pins
        next_st.line_tx = tx_src;
        if (st.lb_act == tllc_pkg::TLLC_LB_REV_PAR || st.lb_act == tllc_pkg::TLLC_LB_REV_SER) begin
            next_st.line_tx.data  = line_rx_word_in;
            next_st.line_tx.valid = line_rx_valid_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            st        <= '0;
            st.ctrl   <= tllc_pkg::TLLC_CTRL_RESET;
            st.rx_buf_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = !st.aw_ok;
    assign s_axi_wready  = !st.w_ok;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign rx_data_out       = st.rx_reg.data;
    assign rx_valid_out      = st.rx_reg.valid;
    assign line_tx_word_out  = st.line_tx.data;
    assign line_tx_valid_out = st.line_tx.valid;
    assign rx_buf_en_out     = st.rx_buf_en;
    assign rx_slip_count_out = st.slip_count;
    assign pfd_feedback_out  = st.pfd;
    assign bonded_out        = st.bonded;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk_in = 1'h0;
    logic        resetn_in = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'h0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'h0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'h0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'h0;
    logic [9:0]  tx_data_in;
    logic        tx_valid_in;
    logic        tx_ready_out;
    logic [9:0]  rx_data_out;
    logic        rx_valid_out;
    logic        tx_detect_loop_in = 1'h0;
    logic [1:0]  power_state_in = 2'h0;
    logic [9:0]  line_rx_word_in = 10'h000;
    logic        line_rx_valid_in = 1'h0;
    logic [4:0]  align_slip_in = 5'h00;
    logic        align_sync_in = 1'h0;
    logic [9:0]  line_tx_word_out;
    logic        line_tx_valid_out;
    logic        rx_buf_en_out;
    logic [4:0]  rx_slip_count_out;
    logic        pfd_feedback_out;
    logic        bonded_out;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [9:0]  rx_q[$];
    logic [9:0]  tx_q[$];
    logic [9:0]  prev = 10'h000;
    logic [4:0]  slip = 5'h00;
    logic [4:0]  v;
    logic [1:0]  e;
    logic [31:0] rd;
    logic [1:0]  rr;

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    tllc_top #(.FIFO_DEPTH(8)) dut_u (.*);
    tllc_fab_model fab_u (.core_clk_in, .ready_in(tx_ready_out), .data_out(tx_data_in),
        .valid_out(tx_valid_in));

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic give_up(string n);
        check(n, 32'h0, 32'h1);
        print_verdict();
    endtask

    task automatic axi_wr(logic [7:0] a, logic [31:0] d,
                          logic [1:0] er = tllc_pkg::TLLC_RESP_OKAY);
        bit aw, w, b;
        bit ad = 0;
        bit wd = 0;
        logic [1:0] r;
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(negedge core_clk_in);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            @(posedge core_clk_in);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            ad |= aw;
            wd |= w;
            if (++n > 50) give_up("write request");
        end
        do begin
            @(negedge core_clk_in);
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk_in);
            if (++n > 100) give_up("write response");
        end while (!b);
        s_axi_bready <= 1'h0;
        check("bresp", 32'(r), 32'(er));
        @(posedge core_clk_in);
    endtask

    task automatic axi_rd(logic [7:0] a);
        bit t;
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge core_clk_in);
            t = s_axi_arready;
            @(posedge core_clk_in);
            if (++n > 50) give_up("read request");
        end while (!t);
        s_axi_arvalid <= 1'h0;
        do begin
            @(negedge core_clk_in);
            t = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge core_clk_in);
            if (++n > 100) give_up("read data");
        end while (!t);
        s_axi_rready <= 1'h0;
        @(posedge core_clk_in);
    endtask

    // Expected line word: stream delayed by slip bits, older bits from the previous word
    task automatic tx_send(int n, bit lp);
        logic [9:0]  w;
        logic [19:0] cat;
        for (int i = 0; i < n; i++) begin
            w = 10'($urandom);
            cat = {w, prev} >> (10 - slip);
            tx_q.push_back(cat[9:0]);
            if (lp) rx_q.push_back(w);
            prev = w;
            fab_u.send(w, i == n - 1);
        end
        @(posedge core_clk_in);
    endtask

    task automatic rx_send(int n, bit to_rx, bit to_tx);
        logic [9:0] w;
        for (int i = 0; i < n; i++) begin
            w = 10'($urandom);
            line_rx_word_in <= w;
            line_rx_valid_in <= 1'h1;
            if (to_rx) rx_q.push_back(w);
            if (to_tx) tx_q.push_back(w);
            @(posedge core_clk_in);
        end
        line_rx_valid_in <= 1'h0;
        line_rx_word_in <= ~w;
        @(posedge core_clk_in);
    endtask

    task automatic drain(string n);
        repeat (16) @(posedge core_clk_in);
        check("rx words missing", 32'(rx_q.size()), 32'h0);
        check("tx words missing", 32'(tx_q.size()), 32'h0);
        $display("test %s done", n);
    endtask

    always @(negedge core_clk_in) begin
        if (resetn_in && rx_valid_out !== 1'h0) begin
            if (rx_q.size() == 0) check("rx extra word", 32'h1, 32'h0);
            else check("rx word", 32'(rx_data_out), 32'(rx_q.pop_front()));
        end
        if (resetn_in && line_tx_valid_out !== 1'h0) begin
            if (tx_q.size() == 0) check("tx extra word", 32'h1, 32'h0);
            else check("tx word", 32'(line_tx_word_out), 32'(tx_q.pop_front()));
        end
    end

    initial begin
        void'($urandom(6428));
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'h1;
        @(posedge core_clk_in);
        axi_rd(tllc_pkg::TLLC_REG_CTRL);
        check("ctrl reset", rd, tllc_pkg::TLLC_CTRL_RESET);
        check("rx buffer reset", 32'(rx_buf_en_out), 32'h1);
        axi_wr(8'h10, 32'h3, tllc_pkg::TLLC_RESP_SLVERR);
        axi_rd(8'h10);
        check("unmapped rresp", 32'(rr), 32'(tllc_pkg::TLLC_RESP_SLVERR));
        check("unmapped rdata", rd, 32'h0);
        $display("test registers done");
        axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h1D1);
        v = 5'($urandom % 10);
        align_slip_in <= v;
        align_sync_in <= 1'h1;
        repeat (3) @(posedge core_clk_in);
        align_sync_in <= 1'h0;
        align_slip_in <= ~v;
        repeat (3) @(posedge core_clk_in);
        check("slip count", 32'(rx_slip_count_out), 32'(v));
        check("bonded", 32'(bonded_out), 32'h1);
        check("pfd", 32'(pfd_feedback_out), 32'h1);
        axi_rd(tllc_pkg::TLLC_REG_STATUS);
        check("status", rd & 32'h7F, 32'(v) | 32'h60);
        // Odd passes add the transmit register stage
        for (int s = 0; s <= 10; s++) begin
            axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h1D1 | (32'(s & 1) << 5));
            axi_wr(tllc_pkg::TLLC_REG_SLIP, (s == 10) ? 32'h1F : 32'(s));
            slip = (s == 10) ? 5'h09 : 5'(s);
            tx_send(3, 1'h0);
            repeat (8) @(posedge core_clk_in);
        end
        drain("transmit slip");
        axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h0D1);
        repeat (2) @(posedge core_clk_in);
        check("pfd unequal clocks", 32'(pfd_feedback_out), 32'h0);
        axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h152);
        repeat (2) @(posedge core_clk_in);
        check("bonded in video", 32'(bonded_out), 32'h0);
        axi_wr(tllc_pkg::TLLC_REG_SLIP, 32'h0);
        slip = 5'h00;
        tx_detect_loop_in <= 1'h1;
        for (int m = 0; m < 5; m++) begin
            for (int l = 0; l < 4; l++) begin
                e = ((l == 1 && m == 3) || (l == 2 && m != 3) || (l == 3 && m != 4))
                    ? 2'(l) : 2'h0;
                axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'(m));
                axi_wr(tllc_pkg::TLLC_REG_RECFG, 32'(l));
                repeat (2) @(posedge core_clk_in);
                axi_rd(tllc_pkg::TLLC_REG_STATUS);
                check("loopback", 32'(rd[8:7]), 32'(e));
                check("rx buffer", 32'(rx_buf_en_out), 32'(e != 2'h2));
            end
        end
        $display("test loopback table done");
        axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h0);
        axi_wr(tllc_pkg::TLLC_REG_RECFG, 32'h2);
        tx_send(4, 1'h1);
        rx_send(3, 1'h0, 1'h0);
        drain("serial loopback");
        axi_wr(tllc_pkg::TLLC_REG_CTRL, 32'h3);
        axi_wr(tllc_pkg::TLLC_REG_RECFG, 32'h1);
        rx_send(4, 1'h1, 1'h1);
        drain("reverse parallel");
        tx_detect_loop_in <= 1'h0;
        @(posedge core_clk_in);
        rx_send(4, 1'h1, 1'h0);
        tx_send(3, 1'h0);
        drain("normal path");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- testbench/tllc_fab_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tllc_fab_model (
    // Clock
    input  wire logic       core_clk_in,
    // Transmit stream toward the channel
    input  wire logic       ready_in,
    output logic      [9:0] data_out,
    output logic            valid_out
);
    // Scrambling, framing, CRC and word alignment belong here
    // Slip amount is set by the bench for each pass, not derived from the reported count
    initial begin
        data_out = 10'h000;
        valid_out = 1'h0;
    end

    task automatic send(logic [9:0] w, bit last);
        bit t;
        int n = 0;
        data_out <= w;
        valid_out <= 1'h1;
        do begin
            @(negedge core_clk_in);
            t = ready_in;
            @(posedge core_clk_in);
            n++;
        end while (!t && n < 100);
        if (last) begin
            valid_out <= 1'h0;
            // Released bus shows a changed value, not the last word
            data_out <= ~w;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/tllc_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tllc_top_monitor (
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        resetn_in,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Streams
    input wire logic        tx_valid_in,
    input wire logic        tx_ready_out,
    input wire logic [9:0]  rx_data_out,
    input wire logic        rx_valid_out,
    input wire logic [9:0]  line_rx_word_in,
    input wire logic        line_rx_valid_in,
    input wire logic        line_tx_valid_out,
    input wire logic        rx_buf_en_out
);
    default clocking mon_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence tx_take;
        tx_valid_in && tx_ready_out;
    endsequence

    chk_write_answer: assert property (
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    chk_bvalid_clear: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after taken");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_rvalid_clear: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held after taken");
    chk_error_data: assert property (
        s_axi_rvalid && s_axi_rresp != tllc_pkg::TLLC_RESP_OKAY |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    // Only checked while the line buffer stays active across the word
    chk_rx_pass: assert property (
        rx_buf_en_out && line_rx_valid_in ##1 rx_buf_en_out
        |-> rx_valid_out && rx_data_out == $past(line_rx_word_in))
        else $error("line word not delivered");
    chk_loop_tx_drive: assert property (
        !rx_buf_en_out ##0 tx_take |-> ##[1:6] line_tx_valid_out)
        else $error("line output idle in loopback");
    chk_loop_rx: assert property (
        !rx_buf_en_out ##0 tx_take |-> ##[1:6] rx_valid_out)
        else $error("loopback word not received");

    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_loop: cover property (!rx_buf_en_out ##0 tx_take);
endmodule
bind tllc_top tllc_top_monitor mon_u (.core_clk_in, .resetn_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out,
    .line_rx_word_in, .line_rx_valid_in, .line_tx_valid_out, .rx_buf_en_out);
`default_nettype wire
